// File: verilog/scc_top.sv
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module scc_top #(
    parameter int W = 16,
    parameter int DIV = scc_pkg::CTRL_DIV
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic signed [W-1:0] pos_cmd_delta,
    input wire logic pos_cmd_valid,
    input wire logic signed [W-1:0] loop_speed_cmd,
    input wire logic signed [W-1:0] speed_ctrl_cmd,
    input wire logic signed [W-1:0] loop_torque_cmd,
    input wire logic inertia_select_input,
    output logic ctrl_tick,
    output logic signed [W-1:0] speed_cmd_out,
    output logic signed [W-1:0] torque_cmd_out,
    output logic [15:0] inertia_ratio_out,
    output logic inertia_sel_active
);
    // three clocks per tick at least, the tick spacing check relies on it
    if (W < 8 || W > 32 || DIV < 3) begin : g_chk
        $error("scc_top: W must be 8..32 and DIV at least 3");
    end
    // ======================================================
    // register file
    scc_pkg::scc_cfg_t cfg;
    logic [15:0] wd;
    logic frozen;
    logic dir_rev;
    logic sat_flag;
    assign wd = wdata[15:0];
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg <= '0;
            cfg.sff_tc <= scc_pkg::RST_FF_TC;
            cfg.tff_tc <= scc_pkg::RST_FF_TC;
        end else if (wr) begin
            case (addr)
                scc_pkg::OFS_CTRL: cfg.ctrl <= wdata[5:0];
                scc_pkg::OFS_FEXP: cfg.fexp <= wd;
                scc_pkg::OFS_UNB: cfg.unb <= wd;
                scc_pkg::OFS_FWD: cfg.fwd <= wd;
                scc_pkg::OFS_REV: cfg.rev <= wd;
                scc_pkg::OFS_RAT1: cfg.rat1 <= wd;
                scc_pkg::OFS_RAT2: cfg.rat2 <= wd;
                scc_pkg::OFS_SFF_RATIO: cfg.sff_ratio <= wd;
                scc_pkg::OFS_SFF_TC: cfg.sff_tc <= wd;
                scc_pkg::OFS_TFF_RATIO: cfg.tff_ratio <= wd;
                scc_pkg::OFS_TFF_TC: cfg.tff_tc <= wd;
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                scc_pkg::OFS_CTRL: rdata <= {26'h0, cfg.ctrl};
                scc_pkg::OFS_FEXP: rdata <= {16'h0, cfg.fexp};
                scc_pkg::OFS_UNB: rdata <= {16'h0, cfg.unb};
                scc_pkg::OFS_FWD: rdata <= {16'h0, cfg.fwd};
                scc_pkg::OFS_REV: rdata <= {16'h0, cfg.rev};
                scc_pkg::OFS_RAT1: rdata <= {16'h0, cfg.rat1};
                scc_pkg::OFS_RAT2: rdata <= {16'h0, cfg.rat2};
                scc_pkg::OFS_SFF_RATIO: rdata <= {16'h0, cfg.sff_ratio};
                scc_pkg::OFS_SFF_TC: rdata <= {16'h0, cfg.sff_tc};
                scc_pkg::OFS_TFF_RATIO: rdata <= {16'h0, cfg.tff_ratio};
                scc_pkg::OFS_TFF_TC: rdata <= {16'h0, cfg.tff_tc};
                scc_pkg::OFS_STATUS:
                    rdata <= {28'h0, dir_rev, sat_flag,
                              inertia_sel_active, frozen};
                scc_pkg::OFS_TORQUE:
                    rdata <= 32'(signed'(torque_cmd_out));
                default: rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
    // ======================================================
    // control cycle divider
    logic [15:0] div_cnt;
    always_ff @(posedge clk) begin
        if (srst) begin
            div_cnt <= 16'h0000;
            ctrl_tick <= 1'b0;
        end else if (div_cnt == 16'(DIV - 1)) begin
            div_cnt <= 16'h0000;
            ctrl_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            ctrl_tick <= 1'b0;
        end
    end
    // ======================================================
    // friction and unbalance offsets
    logic servo_on;
    logic pos_mode;
    logic servo_on_d;
    logic cmd_evt;
    logic signed [W-1:0] unb_comp;
    logic signed [W-1:0] fric_comp;
    logic signed [W-1:0] unb_set;
    logic signed [W-1:0] fwd_set;
    logic signed [W-1:0] rev_set;
    assign servo_on = cfg.ctrl[scc_pkg::CTRL_SERVO_ON];
    assign pos_mode = cfg.ctrl[scc_pkg::CTRL_POS_MODE];
    assign cmd_evt = pos_cmd_valid && (pos_cmd_delta != '0);
    assign unb_set = cfg.ctrl[scc_pkg::CTRL_UNB_EN] ?
        W'(signed'(cfg.unb)) : '0;
    assign fwd_set = cfg.ctrl[scc_pkg::CTRL_FRIC_EN] ?
        W'(signed'(cfg.fwd)) : '0;
    assign rev_set = cfg.ctrl[scc_pkg::CTRL_FRIC_EN] ?
        W'(signed'(cfg.rev)) : '0;
    always_ff @(posedge clk) begin
        if (srst) begin
            servo_on_d <= 1'b0;
            frozen <= 1'b0;
            unb_comp <= '0;
            fric_comp <= '0;
            dir_rev <= 1'b0;
        end else if (ctrl_tick) begin
            servo_on_d <= servo_on;
            if (!servo_on && !pos_mode) begin
                unb_comp <= unb_set;
                fric_comp <= '0;
                frozen <= 1'b0;
            end else if (servo_on && pos_mode) begin
                if (cmd_evt) begin
                    frozen <= 1'b0;
                    unb_comp <= unb_set;
                    fric_comp <= pos_cmd_delta[W-1] ? rev_set : fwd_set;
                    dir_rev <= pos_cmd_delta[W-1];
                end else if (!servo_on_d) begin
                    frozen <= 1'b1;
                end
            end else if (servo_on) begin
                unb_comp <= unb_set;
                frozen <= 1'b0;
            end
        end
    end
    // ======================================================
    // inertia ratio selection
    logic sw_allowed;
    assign sw_allowed = cfg.fexp[scc_pkg::FEXP_RATIO_SW] && servo_on &&
        !cfg.ctrl[scc_pkg::CTRL_AUTOTUNE] &&
        !cfg.ctrl[scc_pkg::CTRL_ADAPTIVE] &&
        !cfg.fexp[scc_pkg::FEXP_INST_OBS] &&
        !cfg.fexp[scc_pkg::FEXP_DIST_OBS];
    always_ff @(posedge clk) begin
        if (srst) begin
            inertia_sel_active <= 1'b0;
            inertia_ratio_out <= scc_pkg::RST_WORD;
        end else begin
            // ratio two only when input on; host switches at rest
            inertia_sel_active <= sw_allowed && inertia_select_input;
            inertia_ratio_out <= (sw_allowed && inertia_select_input) ?
                cfg.rat2 : cfg.rat1;
        end
    end
    // ======================================================
    // feed-forward terms
    function automatic logic signed [W-1:0] clip(input logic signed [47:0] v);
        logic signed [47:0] hi;
        logic signed [47:0] lo;
        hi = 48'(signed'({1'b0, {(W-1){1'b1}}}));
        lo = -hi - 48'sd1;
        if (v > hi) begin
            clip = hi[W-1:0];
        end else if (v < lo) begin
            clip = lo[W-1:0];
        end else begin
            clip = v[W-1:0];
        end
    endfunction
    logic signed [W-1:0] spd_prev;
    logic signed [47:0] sff_prod;
    logic signed [47:0] accel;
    logic signed [47:0] tq_der;
    logic signed [47:0] tff_prod;
    logic signed [W-1:0] sff_raw;
    logic signed [W-1:0] tff_raw;
    logic signed [W-1:0] sff_filt;
    logic signed [W-1:0] tff_filt;
    always_comb begin
        // command speed scaled, percent of full
        // delta without valid is not a command, so it must not feed forward
        sff_prod = 48'((pos_mode && pos_cmd_valid) ? pos_cmd_delta : W'(0)) *
            $signed({32'h0, cfg.sff_ratio}) / 48'(scc_pkg::PCT_FULL);
        sff_raw = clip(sff_prod);
        // torque from speed command slope and load inertia
        accel = 48'(speed_ctrl_cmd) - 48'(spd_prev);
        tq_der = accel * ($signed({32'h0, inertia_ratio_out}) +
            48'(scc_pkg::PCT_FULL)) / 48'(scc_pkg::PCT_FULL);
        tff_prod = 48'(clip(tq_der)) *
            $signed({32'h0, cfg.tff_ratio}) / 48'(scc_pkg::PCT_FULL);
        tff_raw = clip(tff_prod);
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            spd_prev <= '0;
        end else if (ctrl_tick) begin
            spd_prev <= speed_ctrl_cmd;
        end
    end
    scc_lag_filter #(.W(W), .TC_W(16)) u_sff_lag (
        .clk(clk),
        .srst(srst),
        .en(ctrl_tick),
        .tc(cfg.sff_tc),
        .x(sff_raw),
        .y(sff_filt)
    );
    scc_lag_filter #(.W(W), .TC_W(16)) u_tff_lag (
        .clk(clk),
        .srst(srst),
        .en(ctrl_tick),
        .tc(cfg.tff_tc),
        .x(tff_raw),
        .y(tff_filt)
    );
    // ======================================================
    // saturating sums
    logic signed [W-1:0] tq_a;
    logic signed [W-1:0] tq_b;
    logic signed [W-1:0] tq_c;
    logic signed [W-1:0] spd_sum;
    logic [3:0] sat_v;
    scc_sat_add #(.W(W)) u_add_unb (
        .a(loop_torque_cmd), .b(unb_comp), .y(tq_a), .sat(sat_v[0])
    );
    scc_sat_add #(.W(W)) u_add_fric (
        .a(tq_a), .b(fric_comp), .y(tq_b), .sat(sat_v[1])
    );
    scc_sat_add #(.W(W)) u_add_tff (
        .a(tq_b), .b(tff_filt), .y(tq_c), .sat(sat_v[2])
    );
    scc_sat_add #(.W(W)) u_add_sff (
        .a(loop_speed_cmd), .b(sff_filt), .y(spd_sum), .sat(sat_v[3])
    );
    always_ff @(posedge clk) begin
        if (srst) begin
            torque_cmd_out <= '0;
            speed_cmd_out <= '0;
            sat_flag <= 1'b0;
        end else if (ctrl_tick) begin
            torque_cmd_out <= tq_c;
            speed_cmd_out <= spd_sum;
            sat_flag <= |sat_v;
        end
    end
    // ======================================================
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    AST_FRIC_ZERO_OFF: assert property (
        ctrl_tick && !servo_on && !pos_mode |=> fric_comp == '0
    ) else $error("friction offset not zero with servo off");
    AST_UNB_FROM_SET: assert property (
        ctrl_tick && !servo_on && !pos_mode |=> unb_comp == $past(unb_set)
    ) else $error("unbalance offset not taken from setting");
    AST_HOLD_FROZEN: assert property (
        frozen && ctrl_tick && !cmd_evt && servo_on && pos_mode
        |=> $stable(unb_comp) && $stable(fric_comp)
    ) else $error("offsets moved before first command");
    AST_DIR_REV: assert property (
        ctrl_tick && servo_on && pos_mode && cmd_evt &&
        pos_cmd_delta[W-1] |=> fric_comp == $past(rev_set) && dir_rev
    ) else $error("reverse friction offset not applied");
    AST_SW_DISABLED: assert property (
        !cfg.fexp[scc_pkg::FEXP_RATIO_SW] |=> !inertia_sel_active
    ) else $error("ratio two chosen with switching disabled");
    AST_RATIO_TWO: assert property (
        sw_allowed && inertia_select_input
        |=> inertia_ratio_out == $past(cfg.rat2)
    ) else $error("ratio two not applied");
    AST_SERVO_GATE: assert property (
        !servo_on |=> !inertia_sel_active
    ) else $error("switching active with servo off");
    AST_SFF_PASS: assert property (
        ctrl_tick && cfg.sff_tc == 16'h0000 |=> sff_filt == $past(sff_raw)
    ) else $error("speed lag with zero constant not transparent");
    AST_TICK_GAP: assert property (
        ctrl_tick |=> (!ctrl_tick) [*2]
    ) else $error("control ticks too close");
    COV_FREEZE: cover property (frozen ##[1:200] !frozen);
    COV_RATIO2: cover property (inertia_sel_active);
    COV_SAT: cover property (ctrl_tick && (|sat_v));
endmodule // scc_top
`default_nettype wire

// File: verilog/scc_pkg.sv
`default_nettype none
package scc_pkg;
    // ======================================================
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FEXP = 8'h04;
    localparam logic [7:0] OFS_UNB = 8'h08;
    localparam logic [7:0] OFS_FWD = 8'h0C;
    localparam logic [7:0] OFS_REV = 8'h10;
    localparam logic [7:0] OFS_RAT1 = 8'h14;
    localparam logic [7:0] OFS_RAT2 = 8'h18;
    localparam logic [7:0] OFS_SFF_RATIO = 8'h1C;
    localparam logic [7:0] OFS_SFF_TC = 8'h20;
    localparam logic [7:0] OFS_TFF_RATIO = 8'h24;
    localparam logic [7:0] OFS_TFF_TC = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2C;
    localparam logic [7:0] OFS_TORQUE = 8'h30;
    // ======================================================
    // control register bits
    localparam int CTRL_SERVO_ON = 0;
    localparam int CTRL_POS_MODE = 1;
    localparam int CTRL_UNB_EN = 2;
    localparam int CTRL_FRIC_EN = 3;
    localparam int CTRL_AUTOTUNE = 4;
    localparam int CTRL_ADAPTIVE = 5;
    // function expansion bits
    localparam int FEXP_INST_OBS = 0;
    localparam int FEXP_DIST_OBS = 1;
    localparam int FEXP_RATIO_SW = 3;
    // status bits
    localparam int STAT_FROZEN = 0;
    localparam int STAT_RATIO2 = 1;
    localparam int STAT_SAT = 2;
    localparam int STAT_REV = 3;
    // ======================================================
    // reset values and scaling
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] RST_FF_TC = 16'h0032;
    localparam int PCT_FULL = 100;
    // control cycle derived from clock
    localparam int CLK_PERIOD_NS = 5;
    localparam int CTRL_PERIOD_NS = 100;
    localparam int CTRL_DIV = CTRL_PERIOD_NS / CLK_PERIOD_NS;
    // ======================================================
    typedef struct packed {
        logic [5:0] ctrl;
        logic [15:0] fexp;
        logic [15:0] unb;
        logic [15:0] fwd;
        logic [15:0] rev;
        logic [15:0] rat1;
        logic [15:0] rat2;
        logic [15:0] sff_ratio;
        logic [15:0] sff_tc;
        logic [15:0] tff_ratio;
        logic [15:0] tff_tc;
    } scc_cfg_t;
endpackage
`default_nettype wire

// File: verilog/scc_sat_add.sv
`timescale 1ns/1ps
`default_nettype none
module scc_sat_add #(
    parameter int W = 16
) (
    input wire logic signed [W-1:0] a,
    input wire logic signed [W-1:0] b,
    output logic signed [W-1:0] y,
    output logic sat
);
    logic signed [W:0] sum;
    logic signed [W-1:0] max_v;
    logic signed [W-1:0] min_v;
    always_comb begin
        max_v = {1'b0, {(W-1){1'b1}}};
        min_v = {1'b1, {(W-1){1'b0}}};
        sum = {a[W-1], a} + {b[W-1], b};
        sat = sum[W] != sum[W-1];
        if (!sat) begin
            y = sum[W-1:0];
        end else if (sum[W]) begin
            y = min_v;
        end else begin
            y = max_v;
        end
    end
endmodule // scc_sat_add
`default_nettype wire

// File: verilog/scc_lag_filter.sv
`timescale 1ns/1ps
`default_nettype none
module scc_lag_filter #(
    parameter int W = 16,
    parameter int TC_W = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic en,
    input wire logic [TC_W-1:0] tc,
    input wire logic signed [W-1:0] x,
    output logic signed [W-1:0] y
);
    logic signed [W:0] diff;
    logic signed [TC_W+1:0] divisor;
    logic signed [W:0] step;
    logic signed [W:0] next_y;
    // one pole: y moves 1/(tc+1) of the gap per tick, tc=0 passes
    always_comb begin
        diff = {x[W-1], x} - {y[W-1], y};
        divisor = $signed({2'b00, tc}) + $signed((TC_W+2)'(1));
        step = (W+1)'(diff / divisor);
        next_y = {y[W-1], y} + step;
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            y <= '0;
        end else if (en) begin
            y <= next_y[W-1:0];
        end
    end
endmodule // scc_lag_filter
`default_nettype wire

// File: dv/scc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scc_host_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic ctrl_tick,
    input wire logic signed [15:0] set_delta,
    input wire logic set_valid,
    input wire logic set_sel,
    input wire logic signed [15:0] set_step,
    output logic signed [15:0] pos_cmd_delta,
    output logic pos_cmd_valid,
    output logic signed [15:0] speed_ctrl_cmd,
    output logic inertia_select_input
);
    // ==========================================
    // position commands
    // no command: delta line keeps changing so stale data never looks valid
    always_ff @(posedge clk) begin
        if (srst) begin
            pos_cmd_valid <= 1'b0;
            pos_cmd_delta <= 16'sh0000;
        end else begin
            pos_cmd_valid <= set_valid;
            pos_cmd_delta <= set_valid ? set_delta : ~pos_cmd_delta;
        end
    end
    // ==========================================
    // speed ramp and switching input
    always_ff @(posedge clk) begin
        if (srst) begin
            speed_ctrl_cmd <= 16'sh0000;
        end else if (ctrl_tick) begin
            speed_ctrl_cmd <= speed_ctrl_cmd + set_step;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            inertia_select_input <= 1'b0;
        end else if (!set_valid) begin
            inertia_select_input <= set_sel;
        end
    end
endmodule // scc_host_model
`default_nettype wire

// File: dv/scc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scc_top_tb;
    localparam int DIV = 4;
    logic clk, srst, wr, rd, pos_cmd_valid, inertia_select_input;
    logic ctrl_tick, inertia_sel_active, set_valid, set_sel;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, v;
    logic [15:0] inertia_ratio_out;
    logic signed [15:0] pos_cmd_delta, loop_speed_cmd, speed_ctrl_cmd;
    logic signed [15:0] loop_torque_cmd, speed_cmd_out, torque_cmd_out;
    logic signed [15:0] set_delta, set_step;
    int num_errors, comparisons;

    scc_top #(.W(16), .DIV(DIV)) uut (.clk(clk), .srst(srst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pos_cmd_delta(pos_cmd_delta), .pos_cmd_valid(pos_cmd_valid),
        .loop_speed_cmd(loop_speed_cmd), .speed_ctrl_cmd(speed_ctrl_cmd),
        .loop_torque_cmd(loop_torque_cmd),
        .inertia_select_input(inertia_select_input), .ctrl_tick(ctrl_tick),
        .speed_cmd_out(speed_cmd_out), .torque_cmd_out(torque_cmd_out),
        .inertia_ratio_out(inertia_ratio_out),
        .inertia_sel_active(inertia_sel_active));
    scc_host_model u_host (.clk(clk), .srst(srst), .ctrl_tick(ctrl_tick),
        .set_delta(set_delta), .set_valid(set_valid), .set_sel(set_sel),
        .set_step(set_step), .pos_cmd_delta(pos_cmd_delta),
        .pos_cmd_valid(pos_cmd_valid), .speed_ctrl_cmd(speed_ctrl_cmd),
        .inertia_select_input(inertia_select_input));

    // ==========================================
    // helpers
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic summarize();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t reg got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t out got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= {16'h0000, d};
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // outputs lag a tick behind offsets and filters, so allow several
    task automatic tick(input int n);
        repeat (n * DIV) @(posedge clk);
        #1;
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        rd_reg(scc_pkg::OFS_CTRL);
        chk_reg(v, 32'h00000000);
        rd_reg(scc_pkg::OFS_SFF_TC);
        chk_reg(v, 32'h00000032);
        rd_reg(scc_pkg::OFS_TFF_TC);
        chk_reg(v, 32'h00000032);
        rd_reg(8'h3C);
        chk_reg(v, 32'h00000000);
    endtask
    // clocks from one tick to the next, sampled after each edge settles
    task automatic t_tick_rate();
        int n;
        n = 0;
        wait (ctrl_tick);
        @(posedge clk);
        #1;
        n = 1;
        while (!ctrl_tick) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_reg(32'(n), 32'(DIV));
    endtask
    task automatic t_torque_ff();
        wr_reg(scc_pkg::OFS_TFF_RATIO, 16'h0064);
        wr_reg(scc_pkg::OFS_TFF_TC, 16'h0001);
        @(posedge clk);
        set_step <= 16'sh000A;
        tick(12);
        chk_out(torque_cmd_out, 16'h0009);
        wr_reg(scc_pkg::OFS_TFF_TC, 16'h0000);
        tick(3);
        chk_out(torque_cmd_out, 16'h000A);
        @(posedge clk);
        set_step <= 16'sh0000;
        tick(3);
        chk_out(torque_cmd_out, 16'h0000);
    endtask
    task automatic t_offsets();
        wr_reg(scc_pkg::OFS_UNB, 16'h0064);
        wr_reg(scc_pkg::OFS_FWD, 16'h001E);
        wr_reg(scc_pkg::OFS_REV, 16'h0028);
        wr_reg(scc_pkg::OFS_CTRL, 16'h000C);
        @(posedge clk);
        loop_torque_cmd <= 16'sh03E8;
        tick(4);
        chk_out(torque_cmd_out, 16'h044C);
        // servo on first: in speed mode a tick would load the new setting
        wr_reg(scc_pkg::OFS_CTRL, 16'h000F);
        wr_reg(scc_pkg::OFS_UNB, 16'h00C8);
        tick(4);
        chk_out(torque_cmd_out, 16'h044C);
        rd_reg(scc_pkg::OFS_STATUS);
        chk_reg({31'h0, v[0]}, 32'h1);
        @(posedge clk);
        set_delta <= 16'sh0005;
        set_valid <= 1'b1;
        tick(4);
        chk_out(torque_cmd_out, 16'h04CE);
        @(posedge clk);
        set_delta <= -16'sh0005;
        tick(4);
        chk_out(torque_cmd_out, 16'h04D8);
        rd_reg(scc_pkg::OFS_STATUS);
        chk_reg({31'h0, v[3]}, 32'h1);
        wr_reg(scc_pkg::OFS_CTRL, 16'h000B);
        tick(4);
        chk_out(torque_cmd_out, 16'h0410);
    endtask
    task automatic t_speed_ff();
        wr_reg(scc_pkg::OFS_SFF_TC, 16'h0000);
        wr_reg(scc_pkg::OFS_SFF_RATIO, 16'h0032);
        wr_reg(scc_pkg::OFS_CTRL, 16'h0003);
        @(posedge clk);
        loop_speed_cmd <= 16'sh0064;
        set_delta <= 16'sh0028;
        tick(4);
        chk_out(speed_cmd_out, 16'h0078);
        wr_reg(scc_pkg::OFS_SFF_TC, 16'h0001);
        wr_reg(scc_pkg::OFS_SFF_RATIO, 16'h0064);
        tick(12);
        chk_out(speed_cmd_out, 16'h008B);
        wr_reg(scc_pkg::OFS_SFF_TC, 16'h0032);
        rd_reg(scc_pkg::OFS_SFF_TC);
        chk_reg(v, 32'h00000032);
    endtask
    task automatic t_ratio();
        logic [7:0] ctl [8] = '{8'h03, 8'h03, 8'h03, 8'h03,
                                8'h13, 8'h23, 8'h02, 8'h03};
        logic [7:0] fx [8] = '{8'h00, 8'h08, 8'h09, 8'h0A,
                               8'h08, 8'h08, 8'h08, 8'h08};
        logic [7:0] sl = 8'b0111_1111;
        logic [7:0] ac = 8'b0000_0010;
        @(posedge clk);
        set_valid <= 1'b0;
        wr_reg(scc_pkg::OFS_RAT1, 16'h0111);
        wr_reg(scc_pkg::OFS_RAT2, 16'h0222);
        for (int i = 0; i < 8; i++) begin
            wr_reg(scc_pkg::OFS_CTRL, {8'h00, ctl[i]});
            wr_reg(scc_pkg::OFS_FEXP, {8'h00, fx[i]});
            @(posedge clk);
            set_sel <= sl[i];
            tick(2);
            chk_out(inertia_ratio_out, ac[i] ? 16'h0222 : 16'h0111);
            chk_out({15'h0, inertia_sel_active}, {15'h0, ac[i]});
        end
    endtask
    task automatic t_sat();
        wr_reg(scc_pkg::OFS_CTRL, 16'h0004);
        wr_reg(scc_pkg::OFS_UNB, 16'h0100);
        @(posedge clk);
        loop_torque_cmd <= 16'sh7FF0;
        tick(4);
        chk_out(torque_cmd_out, 16'h7FFF);
        rd_reg(scc_pkg::OFS_STATUS);
        chk_reg({31'h0, v[2]}, 32'h1);
        rd_reg(scc_pkg::OFS_TORQUE);
        chk_reg(v, 32'h00007FFF);
        wr_reg(scc_pkg::OFS_UNB, 16'hFF00);
        @(posedge clk);
        loop_torque_cmd <= 16'sh8010;
        tick(4);
        chk_out(torque_cmd_out, 16'h8000);
    endtask

    // ==========================================
    // main sequence and watchdog
    initial begin
        num_errors = 0;
        comparisons = 0;
        srst = 1'b1;
        {wr, rd, set_valid, set_sel} = 4'h0;
        addr = 8'h00;
        wdata = 32'h00000000;
        loop_speed_cmd = 16'sh0000;
        loop_torque_cmd = 16'sh0000;
        set_delta = 16'sh0000;
        set_step = 16'sh0000;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_tick_rate();
        t_torque_ff();
        t_offsets();
        t_speed_ff();
        t_ratio();
        t_sat();
        summarize();
    end
    // run needs well under 5000 cycles
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
endmodule // scc_top_tb
`default_nettype wire
